// file: core/pwr_clk_params.svh
// Offsets, field positions, encodings and counts of the clock/power block
`ifndef PWR_CLK_PARAMS_SVH
`define PWR_CLK_PARAMS_SVH
`define OFS_SYS_CLK_CTRL   8'h00
`define OFS_LOW_PWR_CTRL   8'h04
`define OFS_STBY_CTRL      8'h08
`define OFS_MOD_STOP       8'h0c
`define OFS_MOD_STOP_KIND  8'h10
`define OFS_STATUS         8'h14
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define FACTOR_X1          2'h0
`define FACTOR_X2          2'h1
`define FACTOR_X4          2'h2
`define FACTOR_BAD         2'h3
`define MULT_X1            3'h1
`define MULT_X2            3'h2
`define MULT_X4            3'h4
`define BUS_SEL_FULL       3'h0
`define BUS_SEL_BAD_HI     2'h3
`define WAIT_SEL_RSVD      3'h6
`define WAIT_SEL_SHORT     3'h7
`define WAIT_SHORT_STATES  19'h00010
`define SCC_SWITCH_BIT     3
`define SBC_SLEEP_BIT      7
`define SBC_WAIT_LSB       4
`define SBC_ONE_BIT        3
`define STAT_BUSY_BIT      7
`define STAT_FACTOR_LSB    5
`endif

// file: core/pwr_clk_pkg.sv
// Types shared by the clock and power-mode control block
package pwr_clk_pkg;
  // Operating modes of the power-mode sequencer
  typedef enum logic [4:0] {
    ST_RUN       = 5'h01,
    ST_SLEEP     = 5'h02,
    ST_SW_STBY   = 5'h04,
    ST_WAKE_WAIT = 5'h08,
    ST_HW_STBY   = 5'h10
  } pwr_state_t;
  typedef logic [2:0] wait_sel_t;
endpackage

// file: core/div_if.sv
// Divided-clock bundle between divider and bus clock selector
`timescale 1ns/1ps
interface div_if;
  logic [4:0] div_level;
  logic [4:0] div_tick;
  modport source (output div_level, output div_tick);
  modport sink   (input  div_level, input  div_tick);
endinterface

// file: core/medium_speed_divider.sv
// Medium-speed divider: system clock over 2, 4, 8, 16 and 32
`timescale 1ns/1ps
`include "pwr_clk_params.svh"
module medium_speed_divider
  import pwr_clk_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  // Divided clocks out
  div_if.source     div
);
  logic [4:0] count;
  logic [4:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running synchronous binary count
  always_comb
  begin
    next_count = count + 5'h01;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count <= 5'h00;
    else
      count <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit k toggles at clock over 2^(k+1); tick marks its period end
  assign div.div_level = count;
  genvar k;
  generate
    for (k = 0; k < 5; k++)
    begin : g_tick
      assign div.div_tick[k] = &count[k:0];
    end
  endgenerate
endmodule // medium_speed_divider

// file: core/standby_wait_timer.sv
// Stabilisation wait counter used when leaving standby
`timescale 1ns/1ps
`include "pwr_clk_params.svh"
module standby_wait_timer
  import pwr_clk_pkg::*;
#(
  parameter int WAIT_0 = 8192,
  parameter int WAIT_1 = 16384,
  parameter int WAIT_2 = 32768,
  parameter int WAIT_3 = 65536,
  parameter int WAIT_4 = 131072,
  parameter int WAIT_5 = 262144
)
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  // Control
  input  wire logic start_i,
  input  wait_sel_t sel_i,
  output logic      busy_o,
  output logic      done_o
);
  logic [18:0] count;
  logic [18:0] next_count;
  logic        next_busy;
  logic        next_done;

  // Wait length in states for each select code
  function automatic logic [18:0] wait_states(input wait_sel_t s);
    unique case (s)
      3'h0:            wait_states = 19'(WAIT_0);
      3'h1:            wait_states = 19'(WAIT_1);
      3'h2:            wait_states = 19'(WAIT_2);
      3'h3:            wait_states = 19'(WAIT_3);
      3'h4:            wait_states = 19'(WAIT_4);
      3'h5:            wait_states = 19'(WAIT_5);
      `WAIT_SEL_RSVD:  wait_states = 19'(WAIT_5);
      `WAIT_SEL_SHORT: wait_states = `WAIT_SHORT_STATES;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Load on start, count down, pulse done at zero
  always_comb
  begin
    next_count = count;
    next_busy  = busy_o;
    next_done  = 1'b0;
    if (start_i)
    begin
      next_count = wait_states(sel_i) - 19'h00001;
      next_busy  = 1'b1;
    end
    else if (busy_o)
    begin
      if (count == 19'h00000)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else
        next_count = count - 19'h00001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count  <= 19'h00000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      busy_o <= next_busy;
      done_o <= next_done;
    end
  end
endmodule // standby_wait_timer

// file: core/pll_clock_and_power_mode_control.sv
// Clock multiplier, bus clock select and power-mode sequencer, AXI4-Lite
`timescale 1ns/1ps
`include "pwr_clk_params.svh"
module pll_clock_and_power_mode_control
  import pwr_clk_pkg::*;
#(
  parameter int NUM_MODULES = 8,
  parameter int WAIT_0      = 8192,
  parameter int WAIT_1      = 16384,
  parameter int WAIT_2      = 32768,
  parameter int WAIT_3      = 65536,
  parameter int WAIT_4      = 131072,
  parameter int WAIT_5      = 262144
)
(
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  // AXI4-Lite write
  input  wire logic [7:0]             s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]             s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  // CPU and pins
  input  wire logic                   sleep_exec_i,
  input  wire logic                   program_break_i,
  input  wire logic                   nmi_i,
  input  wire logic [5:0]             external_interrupt_lines_i,
  input  wire logic                   internal_irq_i,
  input  wire logic                   hw_standby_n_i,
  input  wire logic                   external_clock_input_pin_i,
  // Clock outputs
  output logic [2:0]                  pll_mult_o,
  output logic                        pll_phase_mark_o,
  output logic                        clock_gen_run_o,
  output logic                        cpu_clk_en_o,
  output logic                        bus_master_clk_en_o,
  // Mode outputs
  output logic                        break_exception_o,
  output logic                        cpu_regs_lost_o,
  output logic                        io_hold_o,
  output logic                        io_float_o,
  output logic                        irq_enable_o,
  output logic [NUM_MODULES-1:0]      module_clk_en_o,
  output logic [NUM_MODULES-1:0]      module_reset_o
);
  // Registers and their next values
  pwr_state_t             state, next_state;
  logic                   factor_switch_mode, next_factor_switch_mode;
  logic [2:0]             bus_sel, next_bus_sel;
  logic [1:0]             factor_field, next_factor_field;
  logic [1:0]             lp_spare, next_lp_spare;
  logic [1:0]             active_factor, next_active_factor;
  logic                   standby_on_sleep, next_standby_on_sleep;
  wait_sel_t              wait_sel, next_wait_sel;
  logic [NUM_MODULES-1:0] mod_stop, next_mod_stop;
  logic [NUM_MODULES-1:0] mod_kind, next_mod_kind;
  logic                   break_pend, next_break_pend;
  logic                   ext_prev, next_ext_prev;
  logic                   aw_held, next_aw_held;
  logic                   w_held, next_w_held;
  logic [7:0]             aw_addr, next_aw_addr;
  logic [7:0]             w_data, next_w_data;
  logic                   w_lane0, next_w_lane0;
  logic                   next_awready, next_wready, next_bvalid;
  logic                   next_arready, next_rvalid;
  logic [1:0]             next_bresp, next_rresp;
  logic [31:0]            next_rdata;
  logic [2:0]             next_pll_mult;
  logic                   next_phase_mark, next_gen_run, next_cpu_en;
  logic                   next_bus_en, next_break_exc, next_regs_lost;
  logic                   next_io_hold, next_io_float, next_irq_en;
  logic [NUM_MODULES-1:0] next_mod_en, next_mod_rst;
  logic                   timer_start, timer_busy, timer_done;
  logic                   bus_tick;
  logic                   do_write;

  div_if div_bus ();

  // Multiplier value for a factor code
  function automatic logic [2:0] factor_mult(input logic [1:0] f);
    unique case (f)
      `FACTOR_X1:  factor_mult = `MULT_X1;
      `FACTOR_X2:  factor_mult = `MULT_X2;
      `FACTOR_X4:  factor_mult = `MULT_X4;
      `FACTOR_BAD: factor_mult = `MULT_X1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Divider and stabilisation timer
  medium_speed_divider u_div (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .div       (div_bus.source)
  );

  standby_wait_timer #(
    .WAIT_0 (WAIT_0),
    .WAIT_1 (WAIT_1),
    .WAIT_2 (WAIT_2),
    .WAIT_3 (WAIT_3),
    .WAIT_4 (WAIT_4),
    .WAIT_5 (WAIT_5)
  ) u_wait (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .start_i   (timer_start),
    .sel_i     (wait_sel),
    .busy_o    (timer_busy),
    .done_o    (timer_done)
  );

  // Bus master clock pick: full speed or one divided tick
  always_comb
  begin
    if (bus_sel == `BUS_SEL_FULL)
      bus_tick = 1'b1;
    else
      bus_tick = div_bus.div_tick[bus_sel - 3'h1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, mode sequencer and outputs: next values
  always_comb
  begin
    next_state              = state;
    next_factor_switch_mode = factor_switch_mode;
    next_bus_sel            = bus_sel;
    next_factor_field       = factor_field;
    next_lp_spare           = lp_spare;
    next_active_factor      = active_factor;
    next_standby_on_sleep   = standby_on_sleep;
    next_wait_sel           = wait_sel;
    next_mod_stop           = mod_stop;
    next_mod_kind           = mod_kind;
    next_break_pend         = break_pend;
    next_ext_prev           = external_clock_input_pin_i;
    next_aw_held            = aw_held;
    next_w_held             = w_held;
    next_aw_addr            = aw_addr;
    next_w_data             = w_data;
    next_w_lane0            = w_lane0;
    next_bvalid             = s_axi_bvalid_o;
    next_bresp              = s_axi_bresp_o;
    next_rvalid             = s_axi_rvalid_o;
    next_rresp              = s_axi_rresp_o;
    next_rdata              = s_axi_rdata_o;
    next_arready            = s_axi_arready_o;
    next_break_exc          = 1'b0;
    timer_start             = 1'b0;
    // Address and data taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata_i[7:0];
      next_w_lane0 = s_axi_wstrb_i[0];
    end
    do_write = aw_held && w_held && !s_axi_bvalid_o;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      unique case (aw_addr)
        `OFS_SYS_CLK_CTRL:
          if (w_lane0)
          begin
            next_factor_switch_mode = w_data[`SCC_SWITCH_BIT];
            if (w_data[2:1] != `BUS_SEL_BAD_HI)
              next_bus_sel = w_data[2:0];
          end
        `OFS_LOW_PWR_CTRL:
          if (w_lane0)
          begin
            next_lp_spare = w_data[3:2];
            if (w_data[1:0] != `FACTOR_BAD)
            begin
              next_factor_field = w_data[1:0];
              if (factor_switch_mode)
                next_active_factor = w_data[1:0];
            end
          end
        `OFS_STBY_CTRL:
          if (w_lane0)
          begin
            next_standby_on_sleep = w_data[`SBC_SLEEP_BIT];
            next_wait_sel = w_data[`SBC_WAIT_LSB +: 3];
          end
        `OFS_MOD_STOP:
          if (w_lane0)
            next_mod_stop = w_data[NUM_MODULES-1:0];
        `OFS_MOD_STOP_KIND:
          if (w_lane0)
            next_mod_kind = w_data[NUM_MODULES-1:0];
        `OFS_STATUS: ;
        default:
          next_bresp = `RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid_o && s_axi_bready_i)
      next_bvalid = 1'b0;
    // Read decode
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = `RESP_OKAY;
      next_rdata   = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        `OFS_SYS_CLK_CTRL:
          next_rdata[3:0] = {factor_switch_mode, bus_sel};
        `OFS_LOW_PWR_CTRL:
          next_rdata[3:0] = {lp_spare, factor_field};
        `OFS_STBY_CTRL:
          next_rdata[7:3] = {standby_on_sleep, wait_sel, 1'b1};
        `OFS_MOD_STOP:
          next_rdata[NUM_MODULES-1:0] = mod_stop;
        `OFS_MOD_STOP_KIND:
          next_rdata[NUM_MODULES-1:0] = mod_kind;
        `OFS_STATUS:
          next_rdata[7:0] = {timer_busy, active_factor, state};
        default:
          next_rresp = `RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    // Power-mode sequencer; hardware standby pin has priority
    if (!hw_standby_n_i)
      next_state = ST_HW_STBY;
    else
    begin
      unique case (state)
        ST_RUN:
          if (sleep_exec_i)
          begin
            if (standby_on_sleep || program_break_i)
            begin
              next_state         = ST_SW_STBY;
              next_active_factor = factor_field;
              next_break_pend    = program_break_i;
            end
            else
              next_state = ST_SLEEP;
          end
        ST_SLEEP:
          if (nmi_i || |external_interrupt_lines_i || internal_irq_i)
            next_state = ST_RUN;
        ST_SW_STBY:
          if (break_pend || nmi_i || |external_interrupt_lines_i)
          begin
            next_state  = ST_WAKE_WAIT;
            timer_start = 1'b1;
          end
        ST_WAKE_WAIT:
          if (timer_done)
          begin
            next_state      = ST_RUN;
            next_break_exc  = break_pend;
            next_break_pend = 1'b0;
          end
        ST_HW_STBY:
        begin
          next_state  = ST_WAKE_WAIT;
          timer_start = 1'b1;
        end
      endcase
    end
    // Unit enables by mode
    next_pll_mult   = factor_mult(next_active_factor);
    next_gen_run    = !(next_state inside {ST_SW_STBY, ST_HW_STBY});
    next_phase_mark = clock_gen_run_o && external_clock_input_pin_i
                      && !ext_prev;
    next_cpu_en     = (next_state == ST_RUN) && bus_tick;
    next_bus_en     = (next_state inside {ST_RUN, ST_SLEEP}) && bus_tick;
    next_regs_lost  = (next_state == ST_HW_STBY);
    next_io_hold    = (next_state == ST_SW_STBY);
    next_io_float   = (next_state == ST_HW_STBY);
    next_irq_en     = (next_state != ST_HW_STBY);
    if (next_state == ST_HW_STBY)
    begin
      next_mod_en  = '0;
      next_mod_rst = '1;
    end
    else if (next_state inside {ST_SW_STBY, ST_WAKE_WAIT})
    begin
      next_mod_en  = '0;
      next_mod_rst = mod_kind;
    end
    else
    begin
      next_mod_en  = ~mod_stop;
      next_mod_rst = mod_stop & mod_kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state               <= ST_RUN;
      factor_switch_mode  <= 1'b0;
      bus_sel             <= `BUS_SEL_FULL;
      factor_field        <= `FACTOR_X1;
      lp_spare            <= 2'h0;
      active_factor       <= `FACTOR_X1;
      standby_on_sleep    <= 1'b0;
      wait_sel            <= 3'h0;
      mod_stop            <= '0;
      mod_kind            <= '0;
      break_pend          <= 1'b0;
      ext_prev            <= 1'b0;
      aw_held             <= 1'b0;
      w_held              <= 1'b0;
      aw_addr             <= 8'h00;
      w_data              <= 8'h00;
      w_lane0             <= 1'b0;
      s_axi_awready_o     <= 1'b1;
      s_axi_wready_o      <= 1'b1;
      s_axi_bvalid_o      <= 1'b0;
      s_axi_bresp_o       <= `RESP_OKAY;
      s_axi_arready_o     <= 1'b1;
      s_axi_rvalid_o      <= 1'b0;
      s_axi_rresp_o       <= `RESP_OKAY;
      s_axi_rdata_o       <= 32'h0000_0000;
      pll_mult_o          <= `MULT_X1;
      pll_phase_mark_o    <= 1'b0;
      clock_gen_run_o     <= 1'b1;
      cpu_clk_en_o        <= 1'b0;
      bus_master_clk_en_o <= 1'b0;
      break_exception_o   <= 1'b0;
      cpu_regs_lost_o     <= 1'b0;
      io_hold_o           <= 1'b0;
      io_float_o          <= 1'b0;
      irq_enable_o        <= 1'b1;
      module_clk_en_o     <= '0;
      module_reset_o      <= '1;
    end
    else
    begin
      state               <= next_state;
      factor_switch_mode  <= next_factor_switch_mode;
      bus_sel             <= next_bus_sel;
      factor_field        <= next_factor_field;
      lp_spare            <= next_lp_spare;
      active_factor       <= next_active_factor;
      standby_on_sleep    <= next_standby_on_sleep;
      wait_sel            <= next_wait_sel;
      mod_stop            <= next_mod_stop;
      mod_kind            <= next_mod_kind;
      break_pend          <= next_break_pend;
      ext_prev            <= next_ext_prev;
      aw_held             <= next_aw_held;
      w_held              <= next_w_held;
      aw_addr             <= next_aw_addr;
      w_data              <= next_w_data;
      w_lane0             <= next_w_lane0;
      s_axi_awready_o     <= next_awready;
      s_axi_wready_o      <= next_wready;
      s_axi_bvalid_o      <= next_bvalid;
      s_axi_bresp_o       <= next_bresp;
      s_axi_arready_o     <= next_arready;
      s_axi_rvalid_o      <= next_rvalid;
      s_axi_rresp_o       <= next_rresp;
      s_axi_rdata_o       <= next_rdata;
      pll_mult_o          <= next_pll_mult;
      pll_phase_mark_o    <= next_phase_mark;
      clock_gen_run_o     <= next_gen_run;
      cpu_clk_en_o        <= next_cpu_en;
      bus_master_clk_en_o <= next_bus_en;
      break_exception_o   <= next_break_exc;
      cpu_regs_lost_o     <= next_regs_lost;
      io_hold_o           <= next_io_hold;
      io_float_o          <= next_io_float;
      irq_enable_o        <= next_irq_en;
      module_clk_en_o     <= next_mod_en;
      module_reset_o      <= next_mod_rst;
    end
  end
endmodule // pll_clock_and_power_mode_control

// file: testbench/pwr_clk_asserts.sv
// Port-level checks of the clock and power-mode block
`timescale 1ns/1ps
module pwr_clk_asserts #(parameter int NUM_MODULES = 8)
(
  // Watched ports
  input wire logic clk_sys_i, reset_n_i, s_axi_arvalid_i, s_axi_arready_o,
  input wire logic s_axi_rvalid_o, s_axi_rready_i, s_axi_bvalid_o,
  input wire logic s_axi_bready_i, hw_standby_n_i, io_hold_o, io_float_o,
  input wire logic external_clock_input_pin_i, pll_phase_mark_o,
  input wire logic clock_gen_run_o, cpu_clk_en_o, bus_master_clk_en_o,
  input wire logic break_exception_o, cpu_regs_lost_o, irq_enable_o,
  input wire logic [1:0]             s_axi_bresp_o,
  input wire logic [31:0]            s_axi_rdata_o,
  input wire logic [2:0]             pll_mult_o,
  input wire logic [NUM_MODULES-1:0] module_reset_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Clock generation
  property p_mult; pll_mult_o inside {3'h1, 3'h2, 3'h4}; endproperty
  a_mult: assert property (p_mult) else $error("bad factor");
  property p_boot;
    $rose(reset_n_i) |=> pll_mult_o == 3'h1 && cpu_clk_en_o && clock_gen_run_o;
  endproperty
  a_boot: assert property (p_boot) else $error("bad boot");
  property p_phase;
    $rose(external_clock_input_pin_i) && clock_gen_run_o |=>
      pll_phase_mark_o;
  endproperty
  a_phase: assert property (p_phase) else $error("no mark");
  ////////////////////////////////////////////////////////////////////////////
  // Standby modes
  property p_hold;
    io_hold_o |-> !clock_gen_run_o && !cpu_clk_en_o && irq_enable_o;
  endproperty
  a_hold: assert property (p_hold) else $error("bad sw standby");
  property p_hw;
    !hw_standby_n_i |=> io_float_o && cpu_regs_lost_o && !irq_enable_o &&
      (&module_reset_o);
  endproperty
  a_hw: assert property (p_hw) else $error("bad hw standby");
  property p_brk; break_exception_o |-> clock_gen_run_o ##1 !break_exception_o;
  endproperty
  a_brk: assert property (p_brk) else $error("bad break");
  ////////////////////////////////////////////////////////////////////////////
  // Register bus answers
  property p_b; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
    $stable(s_axi_bresp_o); endproperty
  a_b: assert property (p_b) else $error("write answer dropped");
  property p_r; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_r: assert property (p_r) else $error("read answer late");
  property p_rh; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
    $stable(s_axi_rdata_o); endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  c_brk: cover property (break_exception_o);
  c_hold: cover property ($rose(io_hold_o));
  c_flt: cover property ($rose(io_float_o));
endmodule // pwr_clk_asserts
bind pll_clock_and_power_mode_control pwr_clk_asserts
  #(.NUM_MODULES(NUM_MODULES)) u_chk (.*);

// file: testbench/osc_irq_model.sv
// Far-side model: external clock source and interrupt lines
`timescale 1ns/1ps
module osc_irq_model
(
  // Clock and wake request
  input  wire logic clk_sys_i,
  input  wire logic wake_i,
  // Pin and interrupt lines
  output logic       clk_pin_o,
  output logic [5:0] irq_lines_o
);
  logic [1:0] phase = 2'h0;
  // Free-running pin clock at a quarter rate
  always @(posedge clk_sys_i) phase <= phase + 2'h1;
  assign clk_pin_o = phase[1];
  // Wake request lifts one external line
  always @(posedge clk_sys_i) irq_lines_o <= {5'h00, wake_i};
endmodule // osc_irq_model

// file: testbench/pll_clock_and_power_mode_control_tb.sv
// Self-checking bench of the clock and power-mode block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module pll_clock_and_power_mode_control_tb;
  logic clk_sys_i = 0, reset_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0, wake = 0;
  logic sleep_exec_i = 0, program_break_i = 0, nmi_i = 0, internal_irq_i = 0;
  logic hw_standby_n_i = 1, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, pll_phase_mark_o, clock_gen_run_o;
  logic cpu_clk_en_o, bus_master_clk_en_o, break_exception_o, io_hold_o;
  logic cpu_regs_lost_o, io_float_o, irq_enable_o, external_clock_input_pin_i;
  logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, mask, kind;
  logic [7:0]  module_clk_en_o, module_reset_o;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rd;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [2:0]  pll_mult_o, sel = 3'h0, m = 3'h1;
  logic [5:0]  external_interrupt_lines_i;
  int          err_total = 0, comparisons = 0, seed = 13, cnt;
  always #5 clk_sys_i = ~clk_sys_i;
  pll_clock_and_power_mode_control #(.WAIT_0(8)) u_dut (.*);
  osc_irq_model u_far (.clk_sys_i(clk_sys_i), .wake_i(wake),
    .clk_pin_o(external_clock_input_pin_i),
    .irq_lines_o(external_interrupt_lines_i));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task close_out;
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One write or read, held until taken and answered
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= {a, a, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
    {s_axi_arvalid_i, s_axi_rready_i} <= {2{!w}};
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end while (!(w ? s_axi_bvalid_o : s_axi_rvalid_o) && n < 99);
    rd = s_axi_rdata_o;
    resp = w ? s_axi_bresp_o : s_axi_rresp_o;
    {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
    if (n == 99) begin err_total++; close_out; end
  endtask
  // Sleep instruction pulse, optionally with break
  task automatic nap(input logic b);
    @(posedge clk_sys_i);
    {sleep_exec_i, program_break_i} <= {1'h1, b};
    @(posedge clk_sys_i);
    {sleep_exec_i, program_break_i} <= 2'h0;
    @(posedge clk_sys_i);
  endtask
  // Cycles until CPU clock (0) or break pulse (1)
  task automatic wait_for(input logic w, output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys_i);
      c++;
    end while (!(w ? break_exception_o : cpu_clk_en_o) && c < 999);
    if (c == 999) begin err_total++; close_out; end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    bus(0, 8'h14, 0); `CHK("status", 32'h01, rd)
    bus(0, 8'h08, 0); `CHK("stby reg", 32'h08, rd)
    bus(0, 8'h20, 0); `CHK("unmapped", 2'h2, resp)
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 8'h00, c);
      if (c < 6) sel = c;
      bus(0, 8'h00, 0); `CHK("bus sel", {29'h0, sel}, rd)
      cnt = 0;
      repeat (64) @(posedge clk_sys_i) cnt += bus_master_clk_en_o;
      `CHK("bus rate", 64 >> sel, cnt)
    end
    bus(1, 8'h00, 32'h08);
    for (int f = 0; f < 4; f++)
    begin
      bus(1, 8'h04, f);
      if (f < 3) m = 3'h1 << f;
      `CHK("factor now", m, pll_mult_o)
    end
    bus(1, 8'h00, 0);
    bus(1, 8'h04, 1); `CHK("factor held", 3'h4, pll_mult_o)
    mask = $random(seed);
    kind = $random(seed);
    bus(1, 8'h0c, mask);
    @(negedge clk_sys_i); `CHK("mod stop", ~mask, module_clk_en_o)
    bus(1, 8'h10, kind);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, 8'h08, k ? 32'hf8 : 32'h88);
      nap(0);
      `CHK("gen stop", 1'h0, clock_gen_run_o)
      `CHK("factor set", 3'h2, pll_mult_o)
      `CHK("mod reset", kind, module_reset_o)
      if (k) nmi_i <= 1'h1;
      else wake <= 1'h1;
      @(posedge clk_sys_i) {wake, nmi_i} <= 2'h0;
      wait_for(0, cnt);
      `CHK("wake", 1'h1, cnt >= (k ? 16 : 8) && cnt < (k ? 23 : 15))
    end
    bus(1, 8'h08, 32'h08);
    nap(0); `CHK("sleep", 2'h2, {clock_gen_run_o, cpu_clk_en_o})
    internal_irq_i <= 1'h1;
    @(posedge clk_sys_i) internal_irq_i <= 1'h0;
    wait_for(0, cnt); `CHK("sleep exit", 1'h1, cnt < 8)
    nap(1);
    wait_for(1, cnt); `CHK("break", 1'h1, cnt >= 6 && cnt < 20)
    hw_standby_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    `CHK("hw", 2'h2, {io_float_o, irq_enable_o})
    hw_standby_n_i <= 1'h1;
    wait_for(0, cnt);
    bus(0, 8'h14, 0); `CHK("back to run", 32'h21, rd)
    close_out;
  end
endmodule // pll_clock_and_power_mode_control_tb
